// ---- src/cipc_top.sv ----
// Cascaded master/slave interrupt priority core with AHB-Lite registers.
// Assumes synchronous request inputs and a core giving two ack pulses.
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Line 0 highest, line 7 lowest default
// - Specific rotate makes named line lowest
// - Auto rotate puts serviced line lowest
// - Fully nested passes strictly higher only
// - Special nested passes higher or equal
// - Special mask blocks only in-service lines
// - Master holds repeat slave request nested
// - Vector equals base plus line number
// - Vector driven during acknowledge
// - Per-line mask, pending, in-service bits
// - Mask word; read select picks view
// - Direct request: pending, ack, vector
// - Slave request cascades through master line
// - Priority judged against in-service bits
// - Auto clear on master only
// - Specific end clears named line
// - Nonspecific end clears highest in service
// - Edge or level detection selectable
module cipc_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [1:0]  htrans,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  master_req,
  input  wire logic [7:0]  slave_req,
  input  wire logic        inta,
  output logic             int_req,
  output logic [7:0]       vec_data,
  output logic             vec_valid,
  output logic [2:0]       cas_code
);
  import cipc_pkg::*;

  typedef enum logic [1:0] {ACK_IDLE, ACK_WAIT} cipc_ack_t;

  // Bus state
  logic        ap_valid, next_ap_valid;
  logic        ap_write, next_ap_write;
  logic [7:0]  ap_addr, next_ap_addr;
  logic        rd_pend, next_rd_pend;
  logic [31:0] next_hrdata;
  logic        next_hreadyout;
  logic        accept;

  // Register state
  cipc_cfg_t   m_cfg, next_m_cfg, s_cfg, next_s_cfg;
  logic [7:0]  m_mask, next_m_mask, s_mask, next_s_mask;
  cipc_cmd_t   m_cmd, next_m_cmd, s_cmd, next_s_cmd;

  // Acknowledge state
  cipc_ack_t   ack_st, next_ack_st;
  logic [7:0]  vec_hold, next_vec_hold;
  logic [7:0]  next_vec_data;
  logic        next_vec_valid;
  logic [2:0]  next_cas_code;
  logic        next_int_req;
  logic        take, m_ack, s_ack, slave_path;
  logic [7:0]  ack_vec;

  // Controller views
  logic [7:0]  m_pend, m_insv, s_pend, s_insv, m_req;
  logic [2:0]  m_low, s_low, m_sel, s_sel;
  logic        m_smm, s_smm, m_found, s_found, m_int, s_int;

  function automatic cipc_cmd_t cmd_of(input logic [31:0] d);
    cipc_cmd_t c;
    c.valid = 1'b1;
    c.op    = cipc_op_t'(d[CMD_OP_LSB +: 3]);
    c.line  = d[CMD_LINE_LSB +: 3];
    return c;
  endfunction : cmd_of

  // Read select chooses pending or in-service
  function automatic logic [31:0] view_of(input cipc_cfg_t c, input logic [7:0] p,
                                          input logic [7:0] s);
    return {24'h00_0000, (c.rd_insv ? s : p)};
  endfunction : view_of

  always_comb begin
    m_req = master_req;
    m_req[CAS_LINE] = s_int;
  end

  cipc_ctrl #(
    .HAS_AUTO_CLR (1'b1)
  ) u_master (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .req      (m_req),
    .cfg      (m_cfg),
    .mask     (m_mask),
    .cmd      (m_cmd),
    .ack      (m_ack),
    .pend     (m_pend),
    .insv     (m_insv),
    .smm      (m_smm),
    .low      (m_low),
    .found    (m_found),
    .sel_line (m_sel),
    .int_out  (m_int)
  );

  cipc_ctrl #(
    .HAS_AUTO_CLR (1'b0)
  ) u_slave (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .req      (slave_req),
    .cfg      (s_cfg),
    .mask     (s_mask),
    .cmd      (s_cmd),
    .ack      (s_ack),
    .pend     (s_pend),
    .insv     (s_insv),
    .smm      (s_smm),
    .low      (s_low),
    .found    (s_found),
    .sel_line (s_sel),
    .int_out  (s_int)
  );

  // Bus address phase and read wait state
  assign accept = hsel & hready & htrans[1];

  always_comb begin
    next_ap_valid  = 1'b0;
    next_ap_write  = ap_write;
    next_ap_addr   = ap_addr;
    next_rd_pend   = 1'b0;
    next_hreadyout = 1'b1;
    next_hrdata    = hrdata;
    if (accept) begin
      next_ap_valid = 1'b1;
      next_ap_write = hwrite;
      next_ap_addr  = {haddr[7:2], 2'b00};
      if (!hwrite) begin
        next_rd_pend   = 1'b1;
        next_hreadyout = 1'b0;
      end
    end
    if (rd_pend) begin
      if (ap_addr == OFS_MCFG) begin
        next_hrdata = {{(32 - CFG_W){1'b0}}, m_cfg};
      end else if (ap_addr == OFS_MMASK) begin
        next_hrdata = {24'h00_0000, m_mask};
      end else if (ap_addr == OFS_MVIEW) begin
        next_hrdata = view_of(m_cfg, m_pend, m_insv);
      end else if (ap_addr == OFS_SCFG) begin
        next_hrdata = {{(32 - CFG_W){1'b0}}, s_cfg};
      end else if (ap_addr == OFS_SMASK) begin
        next_hrdata = {24'h00_0000, s_mask};
      end else if (ap_addr == OFS_SVIEW) begin
        next_hrdata = view_of(s_cfg, s_pend, s_insv);
      end else if (ap_addr == OFS_STAT) begin
        next_hrdata = 32'h0000_0000;
        next_hrdata[0] = int_req;
        next_hrdata[1] = m_smm;
        next_hrdata[2] = s_smm;
        next_hrdata[STAT_LOW_M +: 3] = m_low;
        next_hrdata[STAT_LOW_S +: 3] = s_low;
        next_hrdata[STAT_VEC_LSB +: 8] = vec_hold;
      end else begin
        next_hrdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid  <= 1'b0;
      ap_write  <= 1'b0;
      ap_addr   <= 8'h00;
      rd_pend   <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else if (ce) begin
      ap_valid  <= next_ap_valid;
      ap_write  <= next_ap_write;
      ap_addr   <= next_ap_addr;
      rd_pend   <= next_rd_pend;
      hreadyout <= next_hreadyout;
      hrdata    <= next_hrdata;
      hresp     <= 1'b0;
    end
  end

  // Register writes in the data phase
  always_comb begin
    next_m_cfg  = m_cfg;
    next_s_cfg  = s_cfg;
    next_m_mask = m_mask;
    next_s_mask = s_mask;
    next_m_cmd  = '0;
    next_s_cmd  = '0;
    if (ap_valid && ap_write) begin
      if (ap_addr == OFS_MCFG) begin
        next_m_cfg = cipc_cfg_t'(hwdata[CFG_W-1:0]);
      end else if (ap_addr == OFS_MMASK) begin
        next_m_mask = hwdata[7:0];
      end else if (ap_addr == OFS_MCMD) begin
        next_m_cmd = cmd_of(hwdata);
      end else if (ap_addr == OFS_SCFG) begin
        next_s_cfg = cipc_cfg_t'(hwdata[CFG_W-1:0]);
      end else if (ap_addr == OFS_SMASK) begin
        next_s_mask = hwdata[7:0];
      end else if (ap_addr == OFS_SCMD) begin
        next_s_cmd = cmd_of(hwdata);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m_cfg  <= CFG_RST;
      s_cfg  <= CFG_RST;
      m_mask <= MASK_RST;
      s_mask <= MASK_RST;
      m_cmd  <= '0;
      s_cmd  <= '0;
    end else if (ce) begin
      m_cfg  <= next_m_cfg;
      s_cfg  <= next_s_cfg;
      m_mask <= next_m_mask;
      s_mask <= next_s_mask;
      m_cmd  <= next_m_cmd;
      s_cmd  <= next_s_cmd;
    end
  end

  // Acknowledge sequence
  assign take       = inta & (ack_st == ACK_IDLE);
  assign slave_path = m_found & (m_sel == CAS_LINE);
  // Master moves its bit on first pulse
  assign m_ack      = take;
  assign s_ack      = take & slave_path;

  // Base plus line; spurious gives line 7
  always_comb begin
    if (!m_found) begin
      ack_vec = m_cfg.base + {5'h00, SPUR_LINE};
    end else if (slave_path) begin
      ack_vec = s_cfg.base + {5'h00, (s_found ? s_sel : SPUR_LINE)};
    end else begin
      ack_vec = m_cfg.base + {5'h00, m_sel};
    end
  end

  always_comb begin
    next_ack_st    = ack_st;
    next_vec_hold  = vec_hold;
    next_vec_data  = vec_data;
    next_vec_valid = 1'b0;
    next_cas_code  = cas_code;
    next_int_req   = m_int;
    case (ack_st)
      ACK_IDLE: begin
        if (inta) begin
          next_vec_hold = ack_vec;
          next_cas_code = slave_path ? CAS_LINE : 3'h0;
          next_ack_st   = ACK_WAIT;
        end
      end
      ACK_WAIT: begin
        if (inta) begin
          next_vec_data  = vec_hold;
          next_vec_valid = 1'b1;
          next_cas_code  = 3'h0;
          next_ack_st    = ACK_IDLE;
        end
      end
      default: next_ack_st = ACK_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_st    <= ACK_IDLE;
      vec_hold  <= 8'h00;
      vec_data  <= 8'h00;
      vec_valid <= 1'b0;
      cas_code  <= 3'h0;
      int_req   <= 1'b0;
    end else if (ce) begin
      ack_st    <= next_ack_st;
      vec_hold  <= next_vec_hold;
      vec_data  <= next_vec_data;
      vec_valid <= next_vec_valid;
      cas_code  <= next_cas_code;
      int_req   <= next_int_req;
    end
  end
endmodule : cipc_top
`default_nettype wire

// ---- shared/cipc_pkg.sv ----
// Package for the cascaded interrupt priority core: map, fields, types.
// Assumes a single clock domain and an AHB-Lite register slave.
`default_nettype none
package cipc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MCFG  = 8'h00;
  localparam logic [7:0] OFS_MMASK = 8'h04;
  localparam logic [7:0] OFS_MCMD  = 8'h08;
  localparam logic [7:0] OFS_MVIEW = 8'h0C;
  localparam logic [7:0] OFS_SCFG  = 8'h10;
  localparam logic [7:0] OFS_SMASK = 8'h14;
  localparam logic [7:0] OFS_SCMD  = 8'h18;
  localparam logic [7:0] OFS_SVIEW = 8'h1C;
  localparam logic [7:0] OFS_STAT  = 8'h20;
  // Field layout
  localparam int CFG_W       = 13;
  localparam int CMD_LINE_LSB = 0;
  localparam int CMD_OP_LSB   = 4;
  localparam int STAT_LOW_M   = 4;
  localparam int STAT_LOW_S   = 8;
  localparam int STAT_VEC_LSB = 16;
  // Reset values, cascade line and spurious line
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] BASE_RST = 8'h20;
  localparam logic [2:0] LOW_RST  = 3'h7;
  localparam logic [2:0] CAS_LINE = 3'h2;
  localparam logic [2:0] SPUR_LINE = 3'h7;

  typedef enum logic [2:0] {
    OP_NONE, OP_EOS_SPEC, OP_EOS_NONSPEC, OP_ROT_SPEC, OP_INIT, OP_SMM_ON, OP_SMM_OFF
  } cipc_op_t;

  typedef struct packed {
    logic       rd_insv;
    logic       auto_rot;
    logic       auto_clr;
    logic       sfnm;
    logic       level;
    logic [7:0] base;
  } cipc_cfg_t;

  typedef struct packed {
    logic       valid;
    cipc_op_t   op;
    logic [2:0] line;
  } cipc_cmd_t;

  localparam cipc_cfg_t CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, BASE_RST};
endpackage : cipc_pkg
`default_nettype wire

// ---- src/cipc_ctrl.sv ----
// One eight-line priority controller: pending, in-service, rotation.
// Assumes command and acknowledge strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module cipc_ctrl #(
  parameter bit HAS_AUTO_CLR = 1'b1
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               ce,
  input  wire logic [7:0]         req,
  input  wire cipc_pkg::cipc_cfg_t cfg,
  input  wire logic [7:0]         mask,
  input  wire cipc_pkg::cipc_cmd_t cmd,
  input  wire logic               ack,
  output logic [7:0]              pend,
  output logic [7:0]              insv,
  output logic                    smm,
  output logic [2:0]              low,
  output logic                    found,
  output logic [2:0]              sel_line,
  output logic                    int_out
);
  import cipc_pkg::*;

  logic [7:0] req_q, next_req_q, next_pend, next_insv, elig, clr, set;
  logic [2:0] next_low, top_line;
  logic [3:0] isr_top;
  logic       next_smm, aclr;

  function automatic logic [2:0] rank_of(input logic [2:0] ln, input logic [2:0] lo);
    return ln - lo - 3'h1;
  endfunction : rank_of

  // Highest-level set line under the current ordering
  function automatic logic [2:0] pick_line(input logic [7:0] v, input logic [2:0] lo);
    logic [2:0] res;
    logic [2:0] ln;
    res = lo;
    for (int k = 7; k >= 0; k--) begin
      ln = lo + 3'h1 + k[2:0];
      if (v[ln]) res = ln;
    end
    return res;
  endfunction : pick_line

  assign top_line = pick_line(insv, low);
  assign isr_top  = (|insv) ? {1'b0, rank_of(top_line, low)} : 4'h8;
  assign aclr     = HAS_AUTO_CLR & cfg.auto_clr;

  for (genvar g = 0; g < 8; g++) begin : g_elig
    logic [3:0] rk;
    assign rk = {1'b0, rank_of(3'(g), low)};
    assign elig[g] = pend[g] & ~mask[g] &
                     (smm ? ~insv[g] : (cfg.sfnm ? (rk <= isr_top) : (rk < isr_top)));
  end

  assign found    = |elig;
  assign sel_line = pick_line(elig, low);
  assign int_out  = found;

  always_comb begin
    next_req_q = req;
    next_pend  = pend;
    next_insv  = insv;
    next_low   = low;
    next_smm   = smm;
    clr        = 8'h00;
    set        = 8'h00;
    if (ack && found && !aclr) set[sel_line] = 1'b1;
    if (ack && found && aclr && cfg.auto_rot) next_low = sel_line;
    if (cfg.level) begin
      next_pend = req;
    end else begin
      next_pend = (pend & ~((ack && found) ? (8'h01 << sel_line) : 8'h00)) | (req & ~req_q);
    end
    if (cmd.valid) begin
      case (cmd.op)
        OP_EOS_SPEC: begin
          clr[cmd.line] = 1'b1;
          if (cfg.auto_rot) next_low = cmd.line;
        end
        OP_EOS_NONSPEC: begin
          if (|insv) begin
            clr[top_line] = 1'b1;
            if (cfg.auto_rot) next_low = top_line;
          end
        end
        OP_ROT_SPEC: next_low = cmd.line;
        OP_SMM_ON:   next_smm = 1'b1;
        OP_SMM_OFF:  next_smm = 1'b0;
        default: ;
      endcase
    end
    next_insv = (insv & ~clr) | set;
    if (cmd.valid && cmd.op == OP_INIT) begin
      next_pend = 8'h00;
      next_insv = 8'h00;
      next_low  = LOW_RST;
      next_smm  = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= 8'h00;
      pend  <= 8'h00;
      insv  <= 8'h00;
      low   <= LOW_RST;
      smm   <= 1'b0;
    end else if (ce) begin
      req_q <= next_req_q;
      pend  <= next_pend;
      insv  <= next_insv;
      low   <= next_low;
      smm   <= next_smm;
    end
  end
endmodule : cipc_ctrl
`default_nettype wire

// ---- tb/cipc_top_checker.sv ----
// Checker for the interrupt core top: bus timing and acknowledge outputs.
// Assumes it is bound to cipc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cipc_top_checker
  import cipc_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        inta,
  input wire logic [7:0]  vec_data,
  input wire logic        vec_valid,
  input wire logic [2:0]  cas_code
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_taken;
    hsel && hready && htrans[1] && !hwrite && ce;
  endsequence
  sequence wr_taken;
    hsel && hready && htrans[1] && hwrite && ce;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_read_wait: assert property (rd_taken |=> one_wait)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (wr_taken |=> hreadyout)
    else $error("write data phase stalled");
  chk_rdata_hold: assert property ($changed(hrdata) |-> hreadyout && !$past(hreadyout))
    else $error("read data moved outside a read");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_vec_pulse: assert property (vec_valid |=> !vec_valid)
    else $error("vector strobe longer than one cycle");
  chk_vec_cause: assert property (vec_valid |-> $past(inta))
    else $error("vector strobe without acknowledge");
  chk_vec_change: assert property ($changed(vec_data) |-> vec_valid)
    else $error("vector changed outside delivery");
  chk_cas_done: assert property (vec_valid |-> cas_code == 3'h0)
    else $error("cascade code left after delivery");
  chk_cas_value: assert property (cas_code == 3'h0 || cas_code == CAS_LINE)
    else $error("cascade code out of range");
  chk_cas_hold: assert property ($changed(cas_code) |-> $past(inta))
    else $error("cascade code moved without acknowledge");
endmodule : cipc_top_checker
bind cipc_top cipc_top_checker chk_u (.hclk, .hresetn, .ce, .hsel, .hready, .htrans,
  .hwrite, .hrdata, .hreadyout, .hresp, .inta, .vec_data, .vec_valid, .cas_code);
`default_nettype wire

// ---- tb/cipc_core_model.sv ----
// Core model: answers a go strobe with a two-pulse acknowledge.
// Assumes go is a one-cycle strobe from the bench.
`timescale 1ns/1ps
`default_nettype none
module cipc_core_model (
  input wire logic       hclk,
  input wire logic       go,
  input wire logic [1:0] gap,
  input wire logic       int_req,
  output var logic       inta
);
  initial begin
    inta = 1'b0;
    forever begin
      @(posedge hclk);
      if (go) begin
        do @(negedge hclk); while (!int_req);
        @(posedge hclk);
        inta <= 1'b1;
        @(posedge hclk);
        inta <= 1'b0;
        repeat (32'(gap) + 1) @(posedge hclk);
        inta <= 1'b1;
        @(posedge hclk);
        inta <= 1'b0;
      end
    end
  end
endmodule : cipc_core_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Bench for the cascaded interrupt core: registers, requests, acknowledges.
// Assumes the core model and queued expected values.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cipc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [7:0]  master_req = 8'h00;
  logic [7:0]  slave_req = 8'h00;
  logic        go = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  last_vec = 8'h00;
  logic [1:0]  gap = 2'h0;
  logic        rd_ph = 1'b0;
  logic [31:0] seed = 32'h0000_0046;
  logic [31:0] r;
  logic [7:0]  eff;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, inta, int_req, vec_valid;
  logic [7:0]  vec_data;
  logic [2:0]  cas_code;
  int          error_cnt = 0;
  int          samples_checked = 0;
  logic [31:0] exp_rd[$];
  logic [7:0]  exp_vec[$];
  cipc_top dut_u (.hclk, .hresetn, .ce, .hsel, .haddr, .hwrite, .hsize(3'h2),
    .htrans, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .master_req,
    .slave_req, .inta, .int_req, .vec_data, .vec_valid, .cas_code);
  cipc_core_model core_u (.hclk, .go, .gap, .int_req, .inta);
  always #5 hclk = ~hclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(negedge hclk); while (!hreadyout);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0000_0000;
    rd_ph <= !w;
    if (!w) exp_rd.push_back(d);
    do @(negedge hclk); while (!hreadyout);
    @(posedge hclk);
    rd_ph <= 1'b0;
  endtask : bus
  task automatic ack(input logic [7:0] v);
    exp_vec.push_back(v);
    last_vec = v;
    r = xs();
    gap <= r[1:0];
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    do @(negedge hclk); while (exp_vec.size() != 0);
    @(posedge hclk);
  endtask : ack
  task automatic irq(input logic e);
    repeat (6) @(negedge hclk);
    check({31'h0, int_req}, {31'h0, e});
    @(posedge hclk);
  endtask : irq
  always @(negedge hclk) begin
    if (rd_ph && hreadyout) check(hrdata, exp_rd.pop_front());
    if (vec_valid) check({24'h00_0000, vec_data}, {24'h00_0000, exp_vec.pop_front()});
  end
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(OFS_MCFG, 1'b0, 32'h0000_0020);
    bus(8'h30, 1'b0, 32'h0000_0000);
    bus(OFS_STAT, 1'b0, {8'h00, last_vec, 16'h0770});
    bus(OFS_MCFG, 1'b1, 32'h0000_1040);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      eff = r[7:0] & ~r[15:8] & 8'hFB;
      bus(OFS_MMASK, 1'b1, {24'h00_0000, r[15:8]});
      master_req <= r[7:0] & 8'hFB;
      for (int l = 0; l < 8; l++) begin
        if (eff[l]) begin
          ack(8'h40 + 8'(l));
          bus(OFS_MVIEW, 1'b0, 32'h0000_0001 << l);
          bus(OFS_MCMD, 1'b1, 32'h0000_0020);
        end
      end
      master_req <= 8'h00;
      irq(1'b0);
      bus(OFS_MCMD, 1'b1, 32'h0000_0040);
    end
    bus(OFS_MMASK, 1'b1, 32'h0000_0000);
    bus(OFS_MCMD, 1'b1, 32'h0000_0034);
    bus(OFS_STAT, 1'b0, {8'h00, last_vec, 16'h0740});
    master_req <= 8'h48;
    ack(8'h46);
    bus(OFS_MCMD, 1'b1, 32'h0000_0016);
    ack(8'h43);
    bus(OFS_MCMD, 1'b1, 32'h0000_0013);
    master_req <= 8'h00;
    bus(OFS_MCMD, 1'b1, 32'h0000_0040);
    bus(OFS_STAT, 1'b0, {8'h00, last_vec, 16'h0770});
    bus(OFS_MCFG, 1'b1, 32'h0000_0840);
    master_req <= 8'h20;
    bus(OFS_MVIEW, 1'b0, 32'h0000_0020);
    ack(8'h45);
    bus(OFS_MCMD, 1'b1, 32'h0000_0020);
    master_req <= 8'h00;
    bus(OFS_STAT, 1'b0, {8'h00, last_vec, 16'h0750});
    bus(OFS_MCMD, 1'b1, 32'h0000_0040);
    bus(OFS_SCFG, 1'b1, 32'h0000_1070);
    bus(OFS_MCFG, 1'b1, 32'h0000_1040);
    slave_req <= 8'h08;
    ack(8'h73);
    slave_req <= 8'h09;
    irq(1'b0);
    bus(OFS_MCFG, 1'b1, 32'h0000_1240);
    ack(8'h70);
    bus(OFS_SVIEW, 1'b0, 32'h0000_0009);
    bus(OFS_SCMD, 1'b1, 32'h0000_0010);
    bus(OFS_SCMD, 1'b1, 32'h0000_0013);
    bus(OFS_MVIEW, 1'b0, 32'h0000_0004);
    bus(OFS_MCMD, 1'b1, 32'h0000_0020);
    slave_req <= 8'h00;
    bus(OFS_MCFG, 1'b1, 32'h0000_1040);
    master_req <= 8'h08;
    ack(8'h43);
    bus(OFS_MCMD, 1'b1, 32'h0000_0050);
    master_req <= 8'h28;
    ack(8'h45);
    bus(OFS_MVIEW, 1'b0, 32'h0000_0028);
    bus(OFS_MCMD, 1'b1, 32'h0000_0015);
    bus(OFS_MVIEW, 1'b0, 32'h0000_0008);
    bus(OFS_MCMD, 1'b1, 32'h0000_0060);
    bus(OFS_MCMD, 1'b1, 32'h0000_0020);
    bus(OFS_MVIEW, 1'b0, 32'h0000_0000);
    master_req <= 8'h00;
    bus(OFS_MCFG, 1'b1, 32'h0000_1440);
    master_req <= 8'h80;
    ack(8'h47);
    bus(OFS_MVIEW, 1'b0, 32'h0000_0000);
    master_req <= 8'h00;
    bus(OFS_MCFG, 1'b1, 32'h0000_1140);
    master_req <= 8'h02;
    ack(8'h41);
    bus(OFS_MCMD, 1'b1, 32'h0000_0011);
    ack(8'h41);
    bus(OFS_MCMD, 1'b1, 32'h0000_0011);
    master_req <= 8'h00;
    irq(1'b0);
    // Clock enable low freezes detection
    ce <= 1'b0;
    master_req <= 8'h01;
    irq(1'b0);
    ce <= 1'b1;
    irq(1'b1);
    master_req <= 8'h00;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
